// ### src/trig_gate_pkg.sv
// package: register map, field layout, reset values and timing for trigger/gate control
// assumes a single 25 MHz core clock
package trig_gate_pkg;

   // clock and trigger-out pulse timing
   localparam int CLK_NS = 40;
   localparam int PULSE_NS = 1000;
   localparam int PULSE_W = 6;
   // wider than the printed minimum: round up, then one extra cycle
   localparam logic [PULSE_W-1:0] PULSE_CYC = PULSE_W'((PULSE_NS + CLK_NS - 1) / CLK_NS + 1);
   // fastest legal fsk select toggling by the outside party
   localparam int FSK_MAX_KHZ = 100;

   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_BURST = 8'h04;
   localparam logic [7:0] OFF_PERIOD = 8'h08;
   localparam logic [7:0] OFF_CYCLE = 8'h0c;
   localparam logic [7:0] OFF_CMD = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;

   // control register fields
   localparam int CTRL_W = 10;
   localparam int CTRL_SWEEP = 0;
   localparam int CTRL_BURST = 1;
   localparam int CTRL_FSK = 2;
   localparam int CTRL_GATED = 3;
   localparam int CTRL_NOISE = 4;
   localparam int CTRL_SRC_LO = 5;
   localparam int CTRL_SRC_HI = 6;
   localparam int CTRL_SLOPE = 7;
   localparam int CTRL_TOUT_EN = 8;
   localparam int CTRL_TOUT_SLOPE = 9;
   localparam int CMD_TRIG = 0;

   // status register fields
   localparam int STAT_STATE_LO = 0;
   localparam int STAT_HOP = 3;
   localparam int STAT_PIN = 4;
   localparam int STAT_LEFT_LO = 16;

   // reset values
   localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
   localparam logic [15:0] BURST_RST = 16'h0001;
   localparam logic [23:0] PERIOD_RST = 24'h0003e8;
   localparam logic [15:0] CYCLE_RST = 16'h0019;

   typedef enum logic [1:0] {
      SRC_INT = 2'b00,
      SRC_EXT = 2'b01,
      SRC_BUS = 2'b10
   } src_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SWEEP = 3'b001,
      ST_BURST = 3'b010,
      ST_GATE = 3'b011,
      ST_DRAIN = 3'b100
   } run_t;

endpackage : trig_gate_pkg

// ### src/trig_pin_if.sv
// interface: synchronised trigger pin level and its edges
// assumes producer and consumer share the core clock
`timescale 1ns/1ns
`default_nettype none
interface trig_pin_if;
   logic level;
   logic rise;
   logic fall;
   modport prod (output level, output rise, output fall);
   modport cons (input level, input rise, input fall);
endinterface : trig_pin_if
`default_nettype wire

// ### src/trig_sync.sv
// module: two-stage synchroniser with edge detect for the trigger pin
// assumes the pin is asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
module trig_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   trig_pin_if.prod s
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } sync_t;

   sync_t r_reg;
   sync_t r_next;

   always_comb begin
      r_next = r_reg;
      r_next.s1 = pin;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign s.level = r_reg.s2;
   assign s.rise = r_reg.s2 & ~r_reg.s3;
   assign s.fall = ~r_reg.s2 & r_reg.s3;
endmodule : trig_sync
`default_nettype wire

// ### src/cycle_ticker.sv
// module: marks the end of each waveform cycle while the output runs
// assumes len is the cycle length in clocks; zero acts as one
`timescale 1ns/1ns
`default_nettype none
module cycle_ticker #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic [W-1:0] len,
   output logic tick
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic tick;
   } tick_t;

   tick_t r_reg;
   tick_t r_next;

   always_comb begin
      r_next = r_reg;
      r_next.tick = 1'b0;
      if (!run) begin
         r_next.cnt = '0;
      end else if (len == '0 || r_reg.cnt >= len - 1'b1) begin
         r_next.cnt = '0;
         r_next.tick = 1'b1;
      end else begin
         r_next.cnt = r_reg.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign tick = r_reg.tick;
endmodule : cycle_ticker
`default_nettype wire

// ### src/trig_gate_ctrl.sv
// module: trigger input / gate / trigger output control with wishbone registers
// assumes synth runs while WAVE_RUN is high and holds start phase when low
// Functional notes
// - external source with sweep on: one sweep per selected trigger edge
// - external fsk: pin low selects carrier, pin high selects hop
// - triggered burst emits burst count cycles per trigger from selected source
// - gated burst runs continuously while gate level is true
// - gate false: finish current cycle, then halt at start phase
// - noise in gated mode stops immediately when gate goes false
// - trigger out only in sweep/burst, rising or falling edge at start
// - internal source: 50% square, period equals sweep time or burst period
// - external source: trigger out forced off, connector is an input
// - bus or manual source: pulse over 1 us at each start
// - connector triggers honoured only with external source and mode enabled
// - external edges during a running triggered burst are ignored
// - reset selects the internal trigger source
`timescale 1ns/1ns
`default_nettype none
module trig_gate_ctrl
   import trig_gate_pkg::*;
#(
   parameter int CNT_W = 24,
   parameter int BURST_W = 16
) (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic TRIG_IN,
   output logic TRIG_OUT,
   output logic TRIG_OUT_EN_N,
   output logic WAVE_RUN,
   output logic SWEEP_START,
   output logic BURST_START,
   output logic FSK_HOP
);
   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [BURST_W-1:0] burst_count;
      logic [CNT_W-1:0] period;
      logic [BURST_W-1:0] cyc_len;
      run_t state;
      logic [CNT_W-1:0] per_cnt;
      logic [CNT_W-1:0] sweep_left;
      logic [BURST_W-1:0] burst_left;
      logic [PULSE_W-1:0] pulse_cnt;
      logic bus_trig;
      logic wave_run;
      logic sweep_start;
      logic burst_start;
      logic fsk_hop;
      logic trig_out;
      logic trig_oe_n;
      logic ack;
      logic [31:0] dat;
   } state_t;

   state_t r_reg;
   state_t r_next;
   logic cyc_tick;

   trig_pin_if pin_if ();

   trig_sync u_sync (
      .clk(CORE_CLK),
      .rst(RST),
      .pin(TRIG_IN),
      .s(pin_if.prod)
   );

   cycle_ticker #(.W(BURST_W)) u_ticker (
      .clk(CORE_CLK),
      .rst(RST),
      .run(r_reg.wave_run),
      .len(r_reg.cyc_len),
      .tick(cyc_tick)
   );

   // byte-lane merge of a write into a register word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[8*i +: 8] = din[8*i +: 8];
         end
      end
      return res;
   endfunction : merge

   // picks the configured edge of the synchronised pin
   function automatic logic pick_edge(input logic neg, input logic rise, input logic fall);
      if (neg) begin
         return fall;
      end
      return rise;
   endfunction : pick_edge

   // status word: state, hop, synced pin, burst cycles left
   function automatic logic [31:0] status_word(input run_t st, input logic hop,
                                               input logic lvl,
                                               input logic [BURST_W-1:0] left);
      logic [31:0] w;
      w = '0;
      w[STAT_STATE_LO +: 3] = st;
      w[STAT_HOP] = hop;
      w[STAT_PIN] = lvl;
      w[STAT_LEFT_LO +: BURST_W] = left;
      return w;
   endfunction : status_word

   logic sweep_en;
   logic burst_en;
   logic fsk_ext;
   logic gated;
   logic noise;
   logic slope_neg;
   logic tout_en;
   logic tout_neg;
   src_t src;
   logic gate_mode;
   logic gate_true;
   logic int_on;
   logic int_tick;
   logic ext_trig;
   logic trig;
   logic tout_act;
   logic tout_lvl;
   logic req;

   always_comb begin
      // mode and source decode
      sweep_en = r_reg.ctrl[CTRL_SWEEP];
      burst_en = r_reg.ctrl[CTRL_BURST];
      fsk_ext = r_reg.ctrl[CTRL_FSK];
      gated = r_reg.ctrl[CTRL_GATED];
      noise = r_reg.ctrl[CTRL_NOISE];
      slope_neg = r_reg.ctrl[CTRL_SLOPE];
      tout_en = r_reg.ctrl[CTRL_TOUT_EN];
      tout_neg = r_reg.ctrl[CTRL_TOUT_SLOPE];
      src = src_t'(r_reg.ctrl[CTRL_SRC_HI:CTRL_SRC_LO]);
      gate_mode = burst_en & gated;
      gate_true = pin_if.level ^ slope_neg;
      int_on = (src == SRC_INT) & (sweep_en | burst_en) & ~gate_mode;
      int_tick = int_on & (r_reg.per_cnt == '0);
      // connector edge counts only with external source selected
      ext_trig = (src == SRC_EXT) & pick_edge(slope_neg, pin_if.rise, pin_if.fall);
      trig = int_tick | ext_trig | ((src == SRC_BUS) & r_reg.bus_trig);
      req = WB_CYC_I & WB_STB_I & ~r_reg.ack;

      r_next = r_reg;
      r_next.sweep_start = 1'b0;
      r_next.burst_start = 1'b0;
      r_next.bus_trig = 1'b0;

      // wishbone slave, one wait state, unmapped reads zero
      r_next.ack = req;
      r_next.dat = '0;
      if (req) begin
         r_next.dat = '0;
         if (WB_WE_I) begin
            case (WB_ADR_I)
               OFF_CTRL: begin
                  r_next.ctrl = CTRL_W'(merge(32'(r_reg.ctrl), WB_DAT_I, WB_SEL_I));
               end
               OFF_BURST: begin
                  r_next.burst_count = BURST_W'(merge(32'(r_reg.burst_count), WB_DAT_I,
                                                       WB_SEL_I));
               end
               OFF_PERIOD: begin
                  r_next.period = CNT_W'(merge(32'(r_reg.period), WB_DAT_I, WB_SEL_I));
               end
               OFF_CYCLE: begin
                  r_next.cyc_len = BURST_W'(merge(32'(r_reg.cyc_len), WB_DAT_I, WB_SEL_I));
               end
               OFF_CMD: begin
                  r_next.bus_trig = WB_SEL_I[0] & WB_DAT_I[CMD_TRIG];
               end
               default: begin
                  r_next.bus_trig = 1'b0;
               end
            endcase
         end else begin
            case (WB_ADR_I)
               OFF_CTRL: begin
                  r_next.dat = 32'(r_reg.ctrl);
               end
               OFF_BURST: begin
                  r_next.dat = 32'(r_reg.burst_count);
               end
               OFF_PERIOD: begin
                  r_next.dat = 32'(r_reg.period);
               end
               OFF_CYCLE: begin
                  r_next.dat = 32'(r_reg.cyc_len);
               end
               OFF_STATUS: begin
                  r_next.dat = status_word(r_reg.state, r_reg.fsk_hop, pin_if.level,
                                           r_reg.burst_left);
               end
               default: begin
                  r_next.dat = '0;
               end
            endcase
         end
      end

      // internal period timer, restarts at zero
      if (!int_on) begin
         r_next.per_cnt = '0;
      end else if (r_reg.per_cnt == '0) begin
         r_next.per_cnt = r_reg.period - 1'b1;
      end else begin
         r_next.per_cnt = r_reg.per_cnt - 1'b1;
      end

      // run state machine
      case (r_reg.state)
         ST_IDLE: begin
            if (gate_mode) begin
               if (gate_true) begin
                  r_next.state = ST_GATE;
                  r_next.burst_start = 1'b1;
               end
            end else if (sweep_en && trig) begin
               r_next.state = ST_SWEEP;
               r_next.sweep_left = r_reg.period;
               r_next.sweep_start = 1'b1;
            end else if (burst_en && trig) begin
               r_next.state = ST_BURST;
               r_next.burst_left = r_reg.burst_count;
               r_next.burst_start = 1'b1;
            end
         end
         ST_SWEEP: begin
            if (!sweep_en) begin
               r_next.state = ST_IDLE;
            end else if (trig) begin
               r_next.sweep_left = r_reg.period;
               r_next.sweep_start = 1'b1;
            end else if (r_reg.sweep_left <= 1) begin
               r_next.state = ST_IDLE;
            end else begin
               r_next.sweep_left = r_reg.sweep_left - 1'b1;
            end
         end
         ST_BURST: begin
            // new triggers are not looked at here
            if (!burst_en || gate_mode) begin
               r_next.state = ST_IDLE;
            end else if (cyc_tick) begin
               if (r_reg.burst_left <= 1) begin
                  r_next.state = ST_IDLE;
                  r_next.burst_left = '0;
               end else begin
                  r_next.burst_left = r_reg.burst_left - 1'b1;
               end
            end
         end
         ST_GATE: begin
            if (!gate_mode || !gate_true) begin
               if (noise) begin
                  r_next.state = ST_IDLE;
               end else if (cyc_tick) begin
                  r_next.state = ST_IDLE;
               end else begin
                  r_next.state = ST_DRAIN;
               end
            end
         end
         ST_DRAIN: begin
            if (cyc_tick || noise) begin
               r_next.state = ST_IDLE;
            end
         end
         default: begin
            r_next.state = ST_IDLE;
         end
      endcase

      // low run level makes the synth hold its start phase
      r_next.wave_run = (r_next.state != ST_IDLE);

      // carrier on low pin level, hop on high; slow toggling assumed
      r_next.fsk_hop = fsk_ext & pin_if.level;

      // trigger-out pulse length for bus starts
      if (r_next.sweep_start || r_next.burst_start) begin
         r_next.pulse_cnt = PULSE_CYC;
      end else if (r_reg.pulse_cnt != '0) begin
         r_next.pulse_cnt = r_reg.pulse_cnt - 1'b1;
      end

      // trigger out enable and level
      tout_act = tout_en & (sweep_en | burst_en) & (src != SRC_EXT);
      case (src)
         SRC_INT: begin
            tout_lvl = int_on & (r_next.per_cnt >= (r_reg.period >> 1));
         end
         SRC_BUS: begin
            tout_lvl = (r_next.pulse_cnt != '0);
         end
         default: begin
            tout_lvl = 1'b0;
         end
      endcase
      r_next.trig_out = tout_act ? (tout_lvl ^ tout_neg) : tout_neg;
      r_next.trig_oe_n = ~tout_act;
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         r_reg <= '0;
         r_reg.ctrl <= CTRL_RST;
         r_reg.burst_count <= BURST_RST;
         r_reg.period <= PERIOD_RST;
         r_reg.cyc_len <= CYCLE_RST;
         r_reg.state <= ST_IDLE;
         r_reg.trig_oe_n <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign WB_DAT_O = r_reg.dat;
   assign WB_ACK_O = r_reg.ack;
   assign TRIG_OUT = r_reg.trig_out;
   assign TRIG_OUT_EN_N = r_reg.trig_oe_n;
   assign WAVE_RUN = r_reg.wave_run;
   assign SWEEP_START = r_reg.sweep_start;
   assign BURST_START = r_reg.burst_start;
   assign FSK_HOP = r_reg.fsk_hop;
endmodule : trig_gate_ctrl
`default_nettype wire

// ### testbench/ext_trig_src.sv
// model: outside equipment driving the trigger connector
// assumes one shared clock for timing its levels
`timescale 1ns/1ns
`default_nettype none
module ext_trig_src (
   input wire logic clk,
   output logic pin
);
   initial pin = 1'b0;
   // set a level after an edge, then hold it
   task drive(input logic lvl, input int hold);
      @(posedge clk);
      pin <= lvl;
      repeat (hold) @(posedge clk);
   endtask : drive
endmodule : ext_trig_src
`default_nettype wire

// ### testbench/trig_gate_chk.sv
// checker: bus and trigger timing at the top ports
// assumes the top module ports of trig_gate_ctrl
`timescale 1ns/1ns
`default_nettype none
module trig_gate_chk (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic TRIG_IN,
   input wire logic WAVE_RUN,
   input wire logic SWEEP_START,
   input wire logic BURST_START,
   input wire logic FSK_HOP
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   sequence req_s;
      WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   sequence start_s;
      SWEEP_START || BURST_START;
   endsequence
   ack_in_time_a: assert property (req_s |=> WB_ACK_O)
      else $error("ack missing after request");
   ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
      else $error("ack without request");
   dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
      else $error("read data outside ack");
   fsk_follow_a: assert property (FSK_HOP |-> $past(TRIG_IN, 3))
      else $error("hop without high pin");
   sweep_pulse_a: assert property (SWEEP_START |=> !SWEEP_START)
      else $error("sweep start too long");
   burst_pulse_a: assert property (BURST_START |=> !BURST_START)
      else $error("burst start too long");
   start_run_a: assert property (start_s |-> WAVE_RUN)
      else $error("start without run");
endmodule : trig_gate_chk
bind trig_gate_ctrl trig_gate_chk u_chk (.CORE_CLK(CORE_CLK), .RST(RST),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .TRIG_IN(TRIG_IN), .WAVE_RUN(WAVE_RUN),
   .SWEEP_START(SWEEP_START), .BURST_START(BURST_START), .FSK_HOP(FSK_HOP));
`default_nettype wire

// ### testbench/trig_gate_ctrl_tb.sv
// testbench: trigger, gate and trigger-out scenarios
// assumes ext_trig_src on the pin, checker bound to the top
`timescale 1ns/1ns
`default_nettype none
module trig_gate_ctrl_tb import trig_gate_pkg::*;;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [31:0] dat_o;
   logic ack, pin, tout, toen_n, run, sws, bst, hop;
   int err_count = 0;
   int cmp_count = 0;
   int n_sw = 0;
   int n_bs = 0;
   int n_run = 0;
   ext_trig_src ext (.clk(clk), .pin(pin));
   trig_gate_ctrl dut (.CORE_CLK(clk), .RST(rst), .WB_CYC_I(req), .WB_STB_I(req),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat),
      .WB_DAT_O(dat_o), .WB_ACK_O(ack), .TRIG_IN(pin), .TRIG_OUT(tout),
      .TRIG_OUT_EN_N(toen_n), .WAVE_RUN(run), .SWEEP_START(sws),
      .BURST_START(bst), .FSK_HOP(hop));
   always #20 clk = ~clk;
   always @(posedge clk) begin
      n_sw += int'(sws === 1'b1);
      n_bs += int'(bst === 1'b1);
      n_run += int'(run === 1'b1);
   end
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      req <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = dat_o;
      req <= 1'b0;
      we <= 1'b0;
   endtask : wb
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
      repeat (2) @(posedge clk);
   endtask : wr
   task rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(nm, q, exp);
   endtask : rd
   task wait_start;
      do @(posedge clk); while (!(sws === 1'b1 || bst === 1'b1));
   endtask : wait_start
   task cnt_hi(input int len, output int c);
      c = int'(tout === 1'b1);
      repeat (len - 1) begin
         @(posedge clk);
         c += int'(tout === 1'b1);
      end
   endtask : cnt_hi
   task t_regs;
      rd("ctrl", OFF_CTRL, 32'h0);
      rd("burst", OFF_BURST, 32'h1);
      rd("period", OFF_PERIOD, 32'h3e8);
      rd("cycle", OFF_CYCLE, 32'h19);
      wr(8'h18, 32'hffff_ffff);
      rd("unmapped", 8'h18, 32'h0);
      rd("cmd", OFF_CMD, 32'h0);
      wr(OFF_PERIOD, 32'd20);
      wr(OFF_CYCLE, 32'd4);
      wr(OFF_BURST, 32'd3);
   endtask : t_regs
   task t_sweep;
      wr(OFF_CTRL, 32'h121);
      chk("oe_ext", toen_n, 1'b1);
      n_sw = 0;
      repeat (2) begin
         ext.drive(1'b1, 3);
         ext.drive(1'b0, 3);
      end
      chk("rise_sw", n_sw, 2);
      wr(OFF_CTRL, 32'h1a1);
      n_sw = 0;
      ext.drive(1'b1, 3);
      ext.drive(1'b0, 3);
      repeat (2) @(posedge clk);
      chk("fall_sw", n_sw, 1);
      wr(OFF_CTRL, 32'h020);
      repeat (30) @(posedge clk);
      n_sw = 0;
      n_bs = 0;
      ext.drive(1'b1, 3);
      ext.drive(1'b0, 3);
      repeat (2) @(posedge clk);
      chk("no_mode", n_sw + n_bs, 0);
   endtask : t_sweep
   task t_burst;
      wr(OFF_CTRL, 32'h022);
      n_bs = 0;
      n_run = 0;
      repeat (2) begin
         ext.drive(1'b1, 3);
         ext.drive(1'b0, 3);
      end
      repeat (20) @(posedge clk);
      chk("retrig", n_bs, 1);
      chk("run_len", n_run >= 12 && n_run <= 13, 1'b1);
   endtask : t_burst
   task t_fsk;
      wr(OFF_CTRL, 32'h024);
      ext.drive(1'b1, 125);
      chk("hop", hop, 1'b1);
      rd("status", OFF_STATUS, 32'h18);
      ext.drive(1'b0, 125);
      chk("carrier", hop, 1'b0);
   endtask : t_fsk
   task t_gate(input logic [31:0] ctrl, input logic nz);
      wr(OFF_CYCLE, 32'd20);
      wr(OFF_CTRL, ctrl);
      ext.drive(1'b1, 3);
      repeat (6) @(posedge clk);
      chk("gate_on", run, 1'b1);
      ext.drive(1'b0, 3);
      @(posedge clk);
      chk("gate_off", run, !nz);
      repeat (25) @(posedge clk);
      chk("halted", run, 1'b0);
   endtask : t_gate
   task t_tout;
      int c;
      logic [31:0] q;
      wr(OFF_CYCLE, 32'd4);
      wr(OFF_CTRL, 32'h101);
      wait_start();
      cnt_hi(20, c);
      chk("sq_hi", c, 10);
      chk("oe_int", toen_n, 1'b0);
      wr(OFF_CTRL, 32'h301);
      wait_start();
      chk("fall_out", tout, 1'b0);
      cnt_hi(20, c);
      chk("sq_fall", c, 10);
      wr(OFF_CTRL, 32'h100);
      chk("oe_idle", toen_n, 1'b1);
      wr(OFF_CTRL, 32'h142);
      wb(1'b1, OFF_CMD, 32'h1, q);
      wait_start();
      cnt_hi(30, c);
      chk("bus_w", c > 25, 1'b1);
   endtask : t_tout
   task finish_test;
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_sweep();
      t_burst();
      t_fsk();
      t_gate(32'h02a, 1'b0);
      t_gate(32'h03a, 1'b1);
      t_tout();
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      finish_test();
   end
endmodule : trig_gate_ctrl_tb
`default_nettype wire
